// >>> bench/shs_host_model.sv
/*
  shs_host_model: host processor on the host side of the shared RAM.
  Assumes it shares ref_clk with the port; drives on the falling edge,
  one byte per access, and keeps off the bus while the port initialises.
*/
`default_nettype none

module shs_host_model import shs_pkg::*; (
  input  wire logic              ref_clk,    // block clock
  input  wire logic              hoBusy_q,   // shared area initialising
  input  wire logic [7:0]        hoRdata_q,  // read data
  input  wire logic              hoRvalid_q, // read answer
  output logic                   hoSel,      // bus cycle
  output logic                   hoWr,       // write
  output logic      [ADDR_W-1:0] hoAddr,     // byte offset
  output logic      [7:0]        hoWdata     // write data
);
  timeunit 1ns;
  timeprecision 1ps;

  // bus idle at time zero
  initial begin
    hoSel = 1'b0;
    hoWr = 1'b0;
    hoAddr = '0;
    hoWdata = '0;
  end

  // one byte cycle; released lines show the inverse, not a stale value
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (hoBusy_q !== 1'b0 && n < 4000) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    hoSel <= 1'b1;
    hoWr <= w;
    hoAddr <= a;
    hoWdata <= d;
    @(negedge ref_clk);
    hoSel <= 1'b0;
    hoWr <= 1'b0;
    hoAddr <= ~a;
    hoWdata <= ~d;
  endtask : access

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask : wr

  // read; an absent answer yields unknown so the compare fails
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    int n;
    access(1'b0, a, 8'h00);
    n = 0;
    while (hoRvalid_q !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    d = (hoRvalid_q === 1'b1) ? hoRdata_q : 8'hxx;
  endtask : rd

  // power-up and post-reset: the ownership state is not trusted
  task automatic free_all(input logic [PAGE_W-1:0] page);
    for (int i = 0; i < SEM_COUNT; i++) begin
      wr({page, 8'(i)}, 8'h01);
    end
  endtask : free_all

endmodule : shs_host_model

`default_nettype wire

// >>> bench/tb_shared_ram_semaphore_port.sv
/*
  tb_shared_ram_semaphore_port: self-checking bench for the shared-RAM
  semaphore port with a host model on the host bus.
  Assumes a 50 MHz clock, a shortened watchdog, fixed random seed.
*/
`default_nettype none

module tb_shared_ram_semaphore_port import shs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WDOG_SIM = 64; // short watchdog keeps the run small

  logic ref_clk = 1'b0;
  logic rst, clkEn, niSel, niWr, acqReq, hoSel, hoWr;
  logic [PAGE_W-1:0] semPageCfg;
  logic [15:0] niAddr;
  logic [7:0] niWdata, niRdata_q, hoWdata, hoRdata_q;
  logic [ADDR_W-1:0] hoAddr;
  logic [2:0] acqIdx;
  logic niRvalid_q, acqGrant_q, acqDone_q, wdogFire_q;
  logic hoRvalid_q, hoBusy_q, uplinkIrqN_q, flush_q;
  int err_count, num_checks, grantCnt;

  // 20 ns period
  always #10 ref_clk = ~ref_clk;

  shs_shared_ram_port #(.WDOG_CYCLES(WDOG_SIM)) dut (
    .ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .semPageCfg(semPageCfg),
    .niSel(niSel), .niWr(niWr), .niAddr(niAddr), .niWdata(niWdata),
    .niRdata_q(niRdata_q), .niRvalid_q(niRvalid_q), .acqReq(acqReq),
    .acqIdx(acqIdx), .acqGrant_q(acqGrant_q), .acqDone_q(acqDone_q),
    .wdogFire_q(wdogFire_q), .hoSel(hoSel), .hoWr(hoWr), .hoAddr(hoAddr),
    .hoWdata(hoWdata), .hoRdata_q(hoRdata_q), .hoRvalid_q(hoRvalid_q),
    .hoBusy_q(hoBusy_q), .uplinkIrqN_q(uplinkIrqN_q), .flush_q(flush_q));

  shs_host_model host (
    .ref_clk(ref_clk), .hoBusy_q(hoBusy_q), .hoRdata_q(hoRdata_q),
    .hoRvalid_q(hoRvalid_q), .hoSel(hoSel), .hoWr(hoWr),
    .hoAddr(hoAddr), .hoWdata(hoWdata));

  // hold length measured independently of the engine's own count
  always @(negedge ref_clk) begin
    if (acqGrant_q === 1'b1) grantCnt++;
  end

  task automatic chk_val(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk_val

  task automatic chk_cnt(input string what, input int exp, input int got);
    num_checks++;
    if (got != exp) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  function automatic logic [ADDR_W-1:0] sa(input logic [2:0] i);
    return {semPageCfg, 8'(i)};
  endfunction : sa

  // interface-side byte cycle; read answer awaited a few cycles at most
  task automatic ni_acc(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge ref_clk);
    niSel <= 1'b1;
    niWr <= w;
    niAddr <= a;
    niWdata <= d;
    @(negedge ref_clk);
    niSel <= 1'b0;
    niWr <= 1'b0;
    niAddr <= ~a;
    niWdata <= ~d;
    n = 0;
    while (!w && niRvalid_q !== 1'b1 && n < 3) begin
      @(negedge ref_clk);
      n++;
    end
    q = (w || niRvalid_q === 1'b1) ? niRdata_q : 8'hxx;
  endtask : ni_acc

  // init phase: count low interrupt cycles, then the notification
  task automatic wait_ready;
    int n, irqLow;
    logic [7:0] d;
    n = 0;
    irqLow = 0;
    while (hoBusy_q !== 1'b0 && n < 4000) begin
      @(negedge ref_clk);
      if (uplinkIrqN_q === 1'b0) irqLow++;
      n++;
    end
    chk_cnt("irq low cycles", IRQ_CYCLES, irqLow);
    chk_val("flush after reset", 8'h01, {7'h0, flush_q});
    host.rd(CMD_IN_ADDR, d);
    chk_val("host notify", RESET_NOTIFY_CMD, d);
    ni_acc(1'b0, {4'ha, CMD_IN_ADDR}, 8'h00, d);
    chk_val("ni notify", RESET_NOTIFY_CMD, d);
    host.free_all(semPageCfg);
  endtask : wait_ready

  // engine acquire; host write lands on the engine's take edge if contend
  task automatic eng_acq(input logic [2:0] i, input logic contend);
    logic [7:0] d;
    int n;
    @(negedge ref_clk);
    acqReq <= 1'b1;
    acqIdx <= i;
    grantCnt = 0;
    if (!contend) @(negedge ref_clk);
    host.wr(sa(i), 8'h00);
    acqReq <= 1'b0;
    host.rd(sa(i), d);
    chk_val("host take while held", 8'h01, d);
    n = 0;
    while (acqDone_q !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    chk_val("done pulse", 8'h01, {7'h0, acqDone_q});
    chk_cnt("hold cycles", HOLD_CYCLES, grantCnt);
    chk_val("grant at release", 8'h00, {7'h0, acqGrant_q});
    host.wr(sa(i), 8'h00);
    host.rd(sa(i), d);
    chk_val("host retake", 8'h00, d);
    host.wr(sa(i), 8'h01);
  endtask : eng_acq

  // main sequence
  initial begin
    logic [7:0] d, q;
    logic [3:0] pg;
    logic [ADDR_W-1:0] off;
    int n;
    void'($urandom(32'h7d76));
    {rst, clkEn} = 2'b11;
    {niSel, niWr, acqReq} = 3'b000;
    niAddr = '0;
    niWdata = '0;
    acqIdx = '0;
    err_count = 0;
    num_checks = 0;
    grantCnt = 0;
    semPageCfg = PAGE_W'(1 + $urandom_range(13));
    repeat (10) @(negedge ref_clk);
    chk_val("reset outputs", 8'h07, {5'h0, flush_q, hoBusy_q, uplinkIrqN_q});
    rst = 1'b0;
    wait_ready();
    // every semaphore, any upper bits
    for (int i = 0; i < SEM_COUNT; i++) begin
      host.wr(sa(3'(i)), 8'($urandom) & 8'hfe);
      host.rd(sa(3'(i)), d);
      chk_val("host take", 8'h00, d);
      ni_acc(1'b0, {4'ha, sa(3'(i))}, 8'h00, d);
      chk_val("ni view", 8'h01, d);
      host.wr(sa(3'(i)), 8'($urandom) | 8'h01);
      host.rd(sa(3'(i)), d);
      chk_val("host release", 8'h01, d);
      eng_acq(3'(i), i[0]);
    end
    host.wr(sa(3'd7) + 12'h001, 8'h5a);
    host.rd(sa(3'd7) + 12'h001, d);
    chk_val("byte past group", 8'h5a, d);
    // plain shared bytes both ways
    for (int k = 0; k < 12; k++) begin
      pg = 4'($urandom_range(13));
      if (pg >= semPageCfg) pg++;
      off = {pg, 8'($urandom)};
      d = 8'($urandom);
      if (k[0]) begin
        ni_acc(1'b1, {4'ha, off}, d, q);
        host.rd(off, q);
      end else begin
        host.wr(off, d);
        ni_acc(1'b0, {4'ha, off}, 8'h00, q);
      end
      chk_val("shared byte", d, q);
    end
    // same byte, same edge from both sides: the device write is kept
    off = {pg, 8'($urandom)};
    d = 8'($urandom);
    fork
      host.wr(off, ~d);
      ni_acc(1'b1, {4'ha, off}, d, q);
    join
    host.rd(off, q);
    chk_val("collision", d, q);
    ni_acc(1'b0, 16'hb123, 8'h00, q);
    chk_val("outside window", 8'h00, q);
    // wrong code first, then the cancel
    host.wr(CMD_OUT_ADDR, FLUSH_CANCEL_CMD ^ 8'h01);
    @(negedge ref_clk);
    chk_val("flush kept", 8'h01, {7'h0, flush_q});
    host.wr(CMD_OUT_ADDR, FLUSH_CANCEL_CMD);
    @(negedge ref_clk);
    chk_val("flush cancelled", 8'h00, {7'h0, flush_q});
    // enable low: a take meanwhile must not land
    clkEn = 1'b0;
    host.wr(sa(3'd3), 8'h00);
    clkEn = 1'b1;
    host.rd(sa(3'd3), d);
    chk_val("frozen take", 8'h01, d);
    // engine starves on a host-held semaphore until the watchdog
    host.wr(sa(3'd2), 8'h00);
    @(negedge ref_clk);
    acqReq <= 1'b1;
    acqIdx <= 3'd2;
    @(negedge ref_clk);
    acqReq <= 1'b0;
    n = 0;
    while (wdogFire_q !== 1'b1 && n < WDOG_SIM + 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk_val("watchdog", 8'h01, {7'h0, wdogFire_q});
    chk_val("no grant", 8'h00, {7'h0, acqGrant_q});
    @(negedge ref_clk);
    chk_val("flush on reset", 8'h01, {7'h0, flush_q});
    wait_ready();
    eng_acq(3'd5, 1'b0);
    end_of_test();
  end

  // hang guard, well past the expected few thousand cycles
  initial begin
    #(40000 * 20);
    err_count++;
    end_of_test();
  end

endmodule : tb_shared_ram_semaphore_port

`default_nettype wire

// >>> rtl/shs_pkg.sv
/*
  shs_pkg: constants, codes and state encoding for the shared-RAM
  semaphore port.
  Assumes one 50 MHz block clock; every count below is in those cycles.
*/
`default_nettype none

package shs_pkg;

  // shared RAM geometry and the interface-side window
  localparam int              RAM_BYTES      = 4096;
  localparam int              ADDR_W         = 12;
  localparam logic [15:0]     NI_RAM_FIRST   = 16'ha000;
  localparam logic [15:0]     NI_RAM_LAST    = 16'hafff;

  // semaphore group: eight bytes at the start of a 256-byte page
  localparam int              SEM_COUNT      = 8;
  localparam int              SEM_PAGE_BYTES = 256;
  localparam int              SEM_PAGE_LSB   = $clog2(SEM_PAGE_BYTES);
  localparam int              PAGE_W         = ADDR_W - SEM_PAGE_LSB;

  // control interface structure
  localparam logic [11:0]     CTRL_OFFSET    = 12'hfe0;
  localparam int              CTRL_BYTES     = 32;
  localparam logic [11:0]     CMD_IN_ADDR    = CTRL_OFFSET + 12'h000;
  localparam logic [11:0]     CMD_OUT_ADDR   = CTRL_OFFSET + 12'h001;

  // command codes, values arbitrary
  localparam logic [7:0]      RESET_NOTIFY_CMD = 8'h5a;
  localparam logic [7:0]      FLUSH_CANCEL_CMD = 8'h6c;

  // timing: hold is a fixed number of input clocks, so it scales with them
  localparam int              CLK_PERIOD_NS  = 20;
  localparam int              HOLD_TIME_NS   = 17400;
  localparam int              HOLD_REF_MHZ   = 10;
  localparam int              HOLD_CYCLES    = (HOLD_TIME_NS * HOLD_REF_MHZ + 999) / 1000;
  localparam int              IRQ_LOW_NS     = 10000;
  localparam int              IRQ_CYCLES     = (IRQ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int              WDOG_DEFAULT   = 100000;

  // counter widths and terminal counts
  localparam int              CNT_W          = 16;
  localparam int              WDOG_W         = 24;
  localparam logic [CNT_W-1:0] CLR_LAST      = CNT_W'(CTRL_BYTES - 1);
  localparam logic [CNT_W-1:0] IRQ_LAST      = CNT_W'(IRQ_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST     = CNT_W'(HOLD_CYCLES - 1);

  // interface-side sequencer states, one-hot
  typedef enum logic [6:0] {
    ST_INIT   = 7'h01,
    ST_NOTIFY = 7'h02,
    ST_IDLE   = 7'h04,
    ST_ACQ_WR = 7'h08,
    ST_ACQ_RD = 7'h10,
    ST_HOLD   = 7'h20,
    ST_REL    = 7'h40
  } shs_state_t;

endpackage : shs_pkg

`default_nettype wire

// >>> rtl/shs_sem_bank.sv
/*
  shs_sem_bank: eight one-bit semaphores with an interface port and a
  host port, each able to take (write 0) or release (write 1).
  Assumes both ports are on ref_clk; holds no memory besides ownership.
*/
`default_nettype none

module shs_sem_bank import shs_pkg::*; (
  input  wire logic                 ref_clk, // block clock
  input  wire logic                 rst,     // sync reset, high
  input  wire logic                 clkEn,   // freezes state when low
  input  wire logic                 niWrEn,  // interface semaphore write
  input  wire logic [2:0]           niIdx,   // interface semaphore index
  input  wire logic                 niBit,   // 0 take, 1 release
  input  wire logic                 hoWrEn,  // host semaphore write
  input  wire logic [2:0]           hoIdx,   // host semaphore index
  input  wire logic                 hoBit,   // 0 take, 1 release
  output logic [SEM_COUNT-1:0]      niHeld,  // owned by interface
  output logic [SEM_COUNT-1:0]      hoHeld   // owned by host
);

  logic [SEM_COUNT-1:0] niOwn_q, niOwn_d, hoOwn_q, hoOwn_d;
  logic [SEM_COUNT-1:0] niOne, hoOne, freeNow, niTake, hoTake;

  // one-hot select of the addressed semaphore on each port
  assign niOne   = niWrEn ? (SEM_COUNT'(1) << niIdx) : '0;
  assign hoOne   = hoWrEn ? (SEM_COUNT'(1) << hoIdx) : '0;
  assign freeNow = ~(niOwn_q | hoOwn_q);
  assign niTake  = freeNow & niOne & {SEM_COUNT{~niBit}};
  // interface wins a same-cycle take, so only one side reads back 0
  assign hoTake  = freeNow & hoOne & {SEM_COUNT{~hoBit}} & ~niTake;

  // a release only clears the writer's own ownership
  assign niOwn_d = (niOwn_q & ~(niOne & {SEM_COUNT{niBit}})) | niTake;
  assign hoOwn_d = (hoOwn_q & ~(hoOne & {SEM_COUNT{hoBit}})) | hoTake;
  assign niHeld  = niOwn_q;
  assign hoHeld  = hoOwn_q;

  // reset leaves all held by host: power-up state is not free
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      niOwn_q <= '0;
      hoOwn_q <= '1;
    end else if (clkEn) begin
      niOwn_q <= niOwn_d;
      hoOwn_q <= hoOwn_d;
    end
  end

  default clocking sbc @(posedge ref_clk); endclocking
  default disable iff (rst || !clkEn);

  sem_owner_exclusive_a: assert property ((niOwn_q & hoOwn_q) == '0)
    else $error("semaphore owned by both sides");

  sem_tie_break_a: assert property (
    niWrEn && hoWrEn && !niBit && !hoBit && niIdx == hoIdx && freeNow[niIdx]
    |=> niOwn_q[$past(niIdx)] && !hoOwn_q[$past(niIdx)])
    else $error("simultaneous take not granted to interface alone");

  host_release_a: assert property (
    hoWrEn && hoBit && hoOwn_q[hoIdx] |=> !hoOwn_q[$past(hoIdx)])
    else $error("host release did not free semaphore");

endmodule : shs_sem_bank

`default_nettype wire

// >>> rtl/shs_shared_ram_port.sv
/*
  shs_shared_ram_port: interface-side logic of a dual-ported shared RAM
  with hardware semaphores, flush control and reset notification.
  Assumes host and interface buses are synchronous to ref_clk and the
  host frees semaphores after power-up and after each reset.
*/
`default_nettype none

// Function
// - eight one-bit semaphores at consecutive bytes
// - semaphore base sits on 256-byte page
// - write zero, read zero means owned
// - read one means other side owns; retry
// - simultaneous take granted to exactly one
// - owner releases by writing one
// - interface holds acquired semaphore 174 input clocks
// - waiting too long trips watchdog reset
// - same-byte collisions serialised, interface wins
// - after reset, flush: no messages in/out
// - host flush-cancel returns to normal
// - reset notification is first uplink message
// - shared RAM at 0xA000-0xAFFF interface side
// - control structure at offset 0x0FE0
module shs_shared_ram_port import shs_pkg::*; #(
  parameter int WDOG_CYCLES = WDOG_DEFAULT // acquire wait before self reset
) (
  input  wire logic              ref_clk,     // 50 MHz block clock
  input  wire logic              rst,         // sync reset, high
  input  wire logic              clkEn,       // freezes all state when low
  input  wire logic [PAGE_W-1:0] semPageCfg,  // semaphore page number
  input  wire logic              niSel,       // interface bus cycle
  input  wire logic              niWr,        // interface write
  input  wire logic [15:0]       niAddr,      // interface byte address
  input  wire logic [7:0]        niWdata,     // interface write data
  output logic      [7:0]        niRdata_q,   // interface read data
  output logic                   niRvalid_q,  // interface read answer
  input  wire logic              acqReq,      // start semaphore acquire
  input  wire logic [2:0]        acqIdx,      // semaphore to acquire
  output logic                   acqGrant_q,  // semaphore held by engine
  output logic                   acqDone_q,   // release cycle pulse
  output logic                   wdogFire_q,  // watchdog reset pulse
  input  wire logic              hoSel,       // host bus cycle
  input  wire logic              hoWr,        // host write
  input  wire logic [ADDR_W-1:0] hoAddr,      // host byte offset
  input  wire logic [7:0]        hoWdata,     // host write data
  output logic      [7:0]        hoRdata_q,   // host read data
  output logic                   hoRvalid_q,  // host read answer
  output logic                   hoBusy_q,    // shared area initialising
  output logic                   uplinkIrqN_q,// uplink interrupt, low
  output logic                   flush_q      // discard rx, block tx
);

  // page match and offset bits 7..3 clear select the eight semaphores
  function automatic logic semWin(input logic [ADDR_W-1:0] ofs,
                                  input logic [PAGE_W-1:0] page);
    return ofs[ADDR_W-1:SEM_PAGE_LSB] == page && ofs[SEM_PAGE_LSB-1:3] == '0;
  endfunction : semWin

  // read-back byte: 0 when the reader owns, upper bits zero
  function automatic logic [7:0] semByte(input logic [SEM_COUNT-1:0] held,
                                         input logic [2:0] idx);
    return {7'h00, ~held[idx]};
  endfunction : semByte

  shs_state_t          state_q, state_d;
  logic [CNT_W-1:0]    cnt_q, cnt_d;
  logic [WDOG_W-1:0]   wdog_q;
  logic [2:0]          acqIdx_q;
  logic [PAGE_W-1:0]   semPage_q;
  logic [7:0]          mem [RAM_BYTES];
  logic [SEM_COUNT-1:0] niHeld, hoHeld;

  logic stInit, stNotify, stIdle, stAcqWr, stAcqRd, stHold, stRel;
  logic initPhase, wdogHit;
  logic [ADDR_W-1:0] niOfs, devAddr;
  logic [7:0]        devData;
  logic niInRange, niSemHit, niRamWr, niRead, devWr;
  logic hoAct, hoSemHit, hoRamWr, hoSemWr, hoCancel, hoBlocked;
  logic engSemWr, engBit;

  // state decode
  assign stInit    = state_q == ST_INIT;
  assign stNotify  = state_q == ST_NOTIFY;
  assign stIdle    = state_q == ST_IDLE;
  assign stAcqWr   = state_q == ST_ACQ_WR;
  assign stAcqRd   = state_q == ST_ACQ_RD;
  assign stHold    = state_q == ST_HOLD;
  assign stRel     = state_q == ST_REL;
  assign initPhase = stInit || stNotify;

  // interface address window and semaphore page
  assign niInRange = niAddr >= NI_RAM_FIRST && niAddr <= NI_RAM_LAST;
  assign niOfs     = niAddr[ADDR_W-1:0];
  assign niSemHit  = niInRange && semWin(niOfs, semPage_q);
  // interface firmware is itself restarting while the area initialises
  assign niRamWr   = niSel && niWr && niInRange && !niSemHit && !initPhase;
  assign niRead    = niSel && !niWr && !initPhase;

  // host decode; host is locked out while the area is rebuilt
  assign hoAct     = hoSel && !initPhase;
  assign hoSemHit  = semWin(hoAddr, semPage_q);
  assign hoRamWr   = hoAct && hoWr && !hoSemHit;
  assign hoSemWr   = hoAct && hoWr && hoSemHit;
  assign hoCancel  = hoRamWr && hoAddr == CMD_OUT_ADDR && hoWdata == FLUSH_CANCEL_CMD;

  // engine semaphore writes: 0 in acquire step, 1 in release step
  assign engSemWr  = stAcqWr || stRel;
  assign engBit    = stRel;
  // a read that has just won is never cut off, or the engine would keep the semaphore
  assign wdogHit   = (stAcqWr || (stAcqRd && !niHeld[acqIdx_q])) && wdog_q == WDOG_W'(WDOG_CYCLES - 1);

  // device write port: init clear, notify code, else interface bus
  assign devWr   = initPhase || niRamWr;
  assign devAddr = stInit   ? CTRL_OFFSET + {7'h00, cnt_q[4:0]} :
                   stNotify ? CMD_IN_ADDR : niOfs;
  assign devData = stInit   ? 8'h00 :
                   stNotify ? RESET_NOTIFY_CMD : niWdata;
  // same byte, same cycle: device write kept, host write dropped
  assign hoBlocked = devWr && devAddr == hoAddr;

  shs_sem_bank u_sem (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .niWrEn  (engSemWr),
    .niIdx   (acqIdx_q),
    .niBit   (engBit),
    .hoWrEn  (hoSemWr),
    .hoIdx   (hoAddr[2:0]),
    .hoBit   (hoWdata[0]),
    .niHeld  (niHeld),
    .hoHeld  (hoHeld)
  );

  // sequencer: init clear, notify, then acquire/hold/release service
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    unique case (state_q)
      ST_INIT: begin
        if (cnt_q == CLR_LAST) begin
          state_d = ST_NOTIFY;
          cnt_d   = '0;
        end
      end
      ST_NOTIFY: begin
        if (cnt_q == IRQ_LAST) begin
          state_d = ST_IDLE;
          cnt_d   = '0;
        end
      end
      ST_IDLE: begin
        cnt_d = '0;
        if (acqReq) begin
          state_d = ST_ACQ_WR;
        end
      end
      ST_ACQ_WR: begin
        state_d = ST_ACQ_RD;
      end
      ST_ACQ_RD: begin
        cnt_d   = '0;
        state_d = niHeld[acqIdx_q] ? ST_HOLD : ST_ACQ_WR;
      end
      ST_HOLD: begin
        if (cnt_q == HOLD_LAST) begin
          state_d = ST_REL;
        end
      end
      ST_REL: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_INIT;
        cnt_d   = '0;
      end
    endcase
    // watchdog expiry restarts the interface like any reset
    if (wdogHit) begin
      state_d = ST_INIT;
      cnt_d   = '0;
    end
  end

  // state and counters
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_INIT;
      cnt_q   <= '0;
      wdog_q  <= '0;
    end else if (clkEn) begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      wdog_q  <= (stAcqWr || stAcqRd) && !wdogHit ? wdog_q + 1'b1 : '0;
    end
  end

  // captured index; page strap caught after reset release
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acqIdx_q  <= '0;
      semPage_q <= '0;
    end else if (clkEn) begin
      if (stIdle && acqReq) acqIdx_q <= acqIdx;
      if (stInit) semPage_q <= semPageCfg;
    end
  end

  // status outputs follow the next state so they line up with it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acqGrant_q   <= 1'b0;
      acqDone_q    <= 1'b0;
      wdogFire_q   <= 1'b0;
      hoBusy_q     <= 1'b1;
      uplinkIrqN_q <= 1'b1;
      flush_q      <= 1'b1;
    end else if (clkEn) begin
      acqGrant_q   <= state_d == ST_HOLD;
      acqDone_q    <= state_d == ST_REL;
      wdogFire_q   <= wdogHit;
      hoBusy_q     <= state_d == ST_INIT || state_d == ST_NOTIFY;
      uplinkIrqN_q <= state_d != ST_NOTIFY;
      // re-entering init sets flush; set wins over a same-cycle cancel
      flush_q      <= (state_d == ST_INIT) || (flush_q && !hoCancel);
    end
  end

  // shared RAM; host write first so the device write wins a tie
  always_ff @(posedge ref_clk) begin
    if (clkEn) begin
      if (hoRamWr && !hoBlocked) mem[hoAddr] <= hoWdata;
      if (devWr) mem[devAddr] <= devData;
    end
  end

  // read answers one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      niRdata_q  <= 8'h00;
      niRvalid_q <= 1'b0;
      hoRdata_q  <= 8'h00;
      hoRvalid_q <= 1'b0;
    end else if (clkEn) begin
      niRvalid_q <= niRead;
      hoRvalid_q <= hoAct && !hoWr;
      if (niRead) begin
        niRdata_q <= !niInRange ? 8'h00 :
                     niSemHit ? semByte(niHeld, niOfs[2:0]) : mem[niOfs];
      end
      if (hoAct && !hoWr) begin
        hoRdata_q <= hoSemHit ? semByte(hoHeld, hoAddr[2:0]) : mem[hoAddr];
      end
    end
  end

  // helper: length of each grant, only for checking
  logic [CNT_W-1:0] holdLen_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      holdLen_q <= '0;
    end else if (clkEn) begin
      holdLen_q <= acqGrant_q ? holdLen_q + 1'b1 : '0;
    end
  end

  default clocking mc @(posedge ref_clk); endclocking
  default disable iff (rst || !clkEn);

  sequence acqWon_s;
    stAcqWr ##1 (stAcqRd && niHeld[acqIdx_q] && !wdogHit);
  endsequence

  sequence acqLost_s;
    stAcqWr ##1 (stAcqRd && !niHeld[acqIdx_q] && !wdogHit);
  endsequence

  acquire_win_a: assert property (acqWon_s |=> acqGrant_q && stHold)
    else $error("won semaphore not granted");

  acquire_retry_a: assert property (acqLost_s |=> stAcqWr ##1 stAcqRd)
    else $error("lost acquire not retried");

  hold_time_a: assert property ($fell(acqGrant_q) |-> holdLen_q == HOLD_LAST + 1'b1)
    else $error("semaphore hold length wrong");

  release_step_a: assert property (
    stHold && cnt_q == HOLD_LAST && !wdogHit
    |=> stRel && acqDone_q && !acqGrant_q ##1 !niHeld[acqIdx_q] && stIdle)
    else $error("semaphore not released after hold");

  watchdog_init_a: assert property (wdogFire_q |-> stInit && flush_q && !acqGrant_q)
    else $error("watchdog did not restart interface");

  flush_hold_a: assert property (initPhase |-> flush_q && hoBusy_q)
    else $error("flush not held during init");

  flush_cancel_a: assert property (hoCancel && !wdogHit |=> !flush_q)
    else $error("flush cancel not honoured");

  notify_first_a: assert property (
    $rose(stNotify) |-> !uplinkIrqN_q ##1 mem[CMD_IN_ADDR] == RESET_NOTIFY_CMD)
    else $error("reset notification not posted");

  ni_window_a: assert property (niRead && !niInRange |=> niRvalid_q && niRdata_q == 8'h00)
    else $error("out of window read not zero");

  sem_readback_a: assert property (
    hoAct && !hoWr && hoSemHit
    |=> hoRdata_q[7:1] == 7'h00 && hoRdata_q[0] == !hoHeld[$past(hoAddr[2:0])])
    else $error("semaphore read byte malformed");

  collide_keep_a: assert property (
    hoRamWr && niRamWr && hoAddr == niOfs |=> mem[$past(niOfs)] == $past(niWdata))
    else $error("same byte collision lost device write");

endmodule : shs_shared_ram_port

`default_nettype wire
